// File: src/umon_counter.v
`timescale 1ns/10ps
`include "umon_global_map.vh"
// up counter with software preload and registered wrap pulse
module umon_counter (
  input wire clk_in,
  input wire rst_n_in,
  input wire load_in,
  input wire [`UMON_CTR_W-1:0] load_val_in,
  input wire run_in,
  input wire [3:0] inc_in,
  output reg [`UMON_CTR_W-1:0] count_out,
  output reg wrap_out
);

  wire [`UMON_CTR_W:0] sum = {1'b0, count_out} + {{(`UMON_CTR_W-3){1'b0}}, inc_in};

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_out <= {`UMON_CTR_W{1'b0}};
      wrap_out <= 1'b0;
    end else if (load_in) begin
      // preload of 2^48-N wraps after N events
      count_out <= load_val_in;
      wrap_out <= 1'b0;
    end else if (run_in) begin
      count_out <= sum[`UMON_CTR_W-1:0];
      wrap_out <= sum[`UMON_CTR_W];
    end else begin
      // held value stays readable while frozen
      wrap_out <= 1'b0;
    end
  end

endmodule

// File: src/umon_event_qual.v
`timescale 1ns/10ps
// turns raw event lines into an increment for one counter
module umon_event_qual (
  input wire clk_in,
  input wire rst_n_in,
  input wire [7:0] event_code_in,
  input wire [7:0] subevent_in,
  input wire [7:0] level_in,
  input wire edge_in,
  input wire [31:0] events_in,
  output reg [3:0] inc_out
);

  reg q_prev_r;
  reg [7:0] grp;
  reg [3:0] cnt;
  reg q;
  integer k;

  always @* begin
    grp = 8'h00;
    cnt = 4'h0;
    q = 1'b0;
    inc_out = 4'h0;
    // event_code 0 selects nothing, so the counter stays still
    case (event_code_in)
      8'h01: grp = events_in[7:0];
      8'h02: grp = events_in[15:8];
      8'h03: grp = events_in[23:16];
      8'h04: grp = events_in[31:24];
      default: grp = 8'h00;
    endcase
    grp = grp & subevent_in;
    for (k = 0; k < 8; k = k + 1) begin
      cnt = cnt + {3'b000, grp[k]};
    end
    // compare level and edge filter qualify the event
    if (level_in == 8'h00) begin
      q = (cnt != 4'h0);
    end else begin
      q = ({4'h0, cnt} >= level_in);
    end
    if (edge_in) begin
      inc_out = {3'b000, q & ~q_prev_r};
    end else if (level_in == 8'h00) begin
      inc_out = cnt;
    end else begin
      inc_out = {3'b000, q};
    end
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_prev_r <= 1'b0;
    end else begin
      q_prev_r <= q;
    end
  end

endmodule

// File: src/umon_global_ctl.v
`timescale 1ns/10ps
`include "umon_global_map.vh"
module umon_global_ctl (
  input wire MCLK_IN,
  input wire RST_N_IN,
  input wire [11:0] MSR_ADDR_IN,
  input wire MSR_WR_IN,
  input wire MSR_RD_IN,
  input wire [63:0] MSR_WDATA_IN,
  output reg [63:0] MSR_RDATA_OUT,
  output reg MSR_ACK_OUT,
  output reg MSR_ERR_OUT,
  input wire [`UMON_BOXES-1:0] BOX_WRAP_MSG_IN,
  input wire [`UMON_EVT_W-1:0] EVENTS_IN,
  input wire [`UMON_CORES-1:0] CORE_AWAKE_IN,
  output reg GLOBAL_FREEZE_OUT,
  output reg [`UMON_CORES-1:0] PMI_CORES_OUT,
  output reg [`UMON_CORES-1:0] WAKE_CORES_OUT
);

  ////////////////////////////////////////////////////////////////////////
  // reset release
  reg rst_s1_r;
  reg rst_s2_r;
  wire rst_n = rst_s2_r;

  always @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address decode
  wire wr_gctl = MSR_WR_IN && (MSR_ADDR_IN == `UMON_ADDR_GCTL);
  wire wr_gstat = MSR_WR_IN && (MSR_ADDR_IN == `UMON_ADDR_GSTAT);
  wire wr_gcfg = MSR_WR_IN && (MSR_ADDR_IN == `UMON_ADDR_GCFG);
  wire wr_fctl = MSR_WR_IN && (MSR_ADDR_IN == `UMON_ADDR_FIX_CTL);
  wire wr_fctr = MSR_WR_IN && (MSR_ADDR_IN == `UMON_ADDR_FIX_CTR);
  wire wr_bstat = MSR_WR_IN && (MSR_ADDR_IN == `UMON_ADDR_BOX_STAT);
  wire [1:0] wr_ctl;
  wire [1:0] wr_ctr;
  assign wr_ctl[0] = MSR_WR_IN && (MSR_ADDR_IN == `UMON_ADDR_CTL0);
  assign wr_ctl[1] = MSR_WR_IN && (MSR_ADDR_IN == `UMON_ADDR_CTL1);
  assign wr_ctr[0] = MSR_WR_IN && (MSR_ADDR_IN == `UMON_ADDR_CTR0);
  assign wr_ctr[1] = MSR_WR_IN && (MSR_ADDR_IN == `UMON_ADDR_CTR1);

  wire hold_set_wr = wr_gctl && MSR_WDATA_IN[`UMON_GCTL_HOLD_SET];
  wire hold_rel_wr = wr_gctl && MSR_WDATA_IN[`UMON_GCTL_HOLD_REL];

  ////////////////////////////////////////////////////////////////////////
  // control state
  reg gctl_wake_r;
  reg [`UMON_CORES-1:0] gctl_cores_r;
  reg freeze_r;
  reg [`UMON_GSTAT_W-1:0] gstat_r;
  reg [`UMON_GCFG_W-1:0] gcfg_r;
  reg fix_en_r;
  reg fix_wme_r;
  reg [63:0] ctl_flat_r;
  reg [1:0] box_stat_r;
  reg pmi_pend_r;

  wire [1:0] gen_wrap;
  wire fix_wrap;
  wire [2*`UMON_CTR_W-1:0] gen_cnt;
  wire [`UMON_CTR_W-1:0] fix_cnt;
  wire [1:0] gen_run;
  wire [1:0] gen_wme;

  ////////////////////////////////////////////////////////////////////////
  // overflow messages
  assign gen_wme[0] = ctl_flat_r[`UMON_CTL_WME];
  assign gen_wme[1] = ctl_flat_r[32+`UMON_CTL_WME];
  wire msg_gen = |(gen_wrap & gen_wme);
  wire msg_fix = fix_wrap & fix_wme_r;
  // one bit per reporting box, every source kept
  wire [`UMON_GSTAT_W-1:0] gset = {BOX_WRAP_MSG_IN, msg_gen, msg_fix};
  wire msg_any = |gset;
  // own counters stop in the wrap cycle, others a cycle later
  wire hold_all = freeze_r | msg_any;

  ////////////////////////////////////////////////////////////////////////
  // counters
  genvar i;
  generate
    for (i = 0; i < `UMON_NCTR; i = i + 1) begin : gen_ctr
      wire [31:0] ctl = ctl_flat_r[i*32 +: 32];
      wire [3:0] inc;
      // own enable, no freeze, valid event
      assign gen_run[i] = ctl[`UMON_CTL_EN] && !hold_all && (ctl[7:0] != 8'h00);
      umon_event_qual u_qual (
        .clk_in(MCLK_IN),
        .rst_n_in(rst_n),
        .event_code_in(ctl[`UMON_CTL_EVT_LSB +: 8]),
        .subevent_in(ctl[`UMON_CTL_SUB_LSB +: 8]),
        .level_in(ctl[`UMON_CTL_LVL_LSB +: 8]),
        .edge_in(ctl[`UMON_CTL_EDGE]),
        .events_in(EVENTS_IN),
        .inc_out(inc)
      );
      // cleared by reset or through a data write, no box reset
      umon_counter u_ctr (
        .clk_in(MCLK_IN),
        .rst_n_in(rst_n),
        .load_in(wr_ctr[i]),
        .load_val_in(MSR_WDATA_IN[`UMON_CTR_W-1:0]),
        .run_in(gen_run[i]),
        .inc_in(inc),
        .count_out(gen_cnt[i*`UMON_CTR_W +: `UMON_CTR_W]),
        .wrap_out(gen_wrap[i])
      );
    end
  endgenerate

  umon_counter u_fix (
    .clk_in(MCLK_IN),
    .rst_n_in(rst_n),
    .load_in(wr_fctr),
    .load_val_in(MSR_WDATA_IN[`UMON_CTR_W-1:0]),
    .run_in(fix_en_r && !hold_all),
    .inc_in(4'h1),
    .count_out(fix_cnt),
    .wrap_out(fix_wrap)
  );

  ////////////////////////////////////////////////////////////////////////
  // register writes and status
  reg freeze_nxt;
  reg [`UMON_GSTAT_W-1:0] gstat_nxt;
  reg [1:0] box_stat_nxt;
  integer n;

  always @* begin
    freeze_nxt = freeze_r;
    if (msg_any || hold_set_wr) begin
      freeze_nxt = 1'b1;
    end else if (hold_rel_wr) begin
      freeze_nxt = 1'b0;
    end
    // write-one clears, a new overflow in the same cycle wins
    gstat_nxt = gstat_r;
    if (wr_gstat) begin
      gstat_nxt = gstat_nxt & ~MSR_WDATA_IN[`UMON_GSTAT_W-1:0];
    end
    gstat_nxt = gstat_nxt | gset;
    // per-counter flags inside the box
    box_stat_nxt = box_stat_r;
    if (wr_bstat) begin
      box_stat_nxt = box_stat_nxt & ~MSR_WDATA_IN[1:0];
    end
    box_stat_nxt = box_stat_nxt | gen_wrap;
  end

  always @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      gctl_wake_r <= 1'b0;
      gctl_cores_r <= 15'h0000;
      freeze_r <= 1'b0;
      gstat_r <= 27'h000_0000;
      gcfg_r <= `UMON_GCFG_RESET;
      fix_en_r <= 1'b0;
      fix_wme_r <= 1'b0;
      ctl_flat_r <= {`UMON_CTL_RESET, `UMON_CTL_RESET};
      box_stat_r <= 2'b00;
    end else begin
      freeze_r <= freeze_nxt;
      gstat_r <= gstat_nxt;
      box_stat_r <= box_stat_nxt;
      if (wr_gctl) begin
        gctl_wake_r <= MSR_WDATA_IN[`UMON_GCTL_WAKE];
        gctl_cores_r <= MSR_WDATA_IN[`UMON_GCTL_CORES_MSB:0];
      end
      if (wr_gcfg) begin
        gcfg_r <= MSR_WDATA_IN[`UMON_GCFG_W-1:0];
      end
      if (wr_fctl) begin
        fix_en_r <= MSR_WDATA_IN[`UMON_CTL_EN];
        fix_wme_r <= MSR_WDATA_IN[`UMON_CTL_WME];
      end
      for (n = 0; n < `UMON_NCTR; n = n + 1) begin
        if (wr_ctl[n]) begin
          ctl_flat_r[n*32 +: 32] <= MSR_WDATA_IN[31:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // boxes and cores
  // boxes combine this freeze with their own hold and resets
  reg [`UMON_CORES-1:0] pmi_nxt;
  reg [`UMON_CORES-1:0] wake_nxt;
  reg pend_nxt;

  always @* begin
    pmi_nxt = 15'h0000;
    wake_nxt = 15'h0000;
    pend_nxt = 1'b0;
    if (pmi_pend_r) begin
      pmi_nxt = gctl_cores_r;
    end
    if (msg_any) begin
      if (gctl_wake_r) begin
        // wake sleepers first, interrupt all targets next cycle
        wake_nxt = gctl_cores_r & ~CORE_AWAKE_IN;
        pend_nxt = 1'b1;
      end else begin
        pmi_nxt = pmi_nxt | (gctl_cores_r & CORE_AWAKE_IN);
      end
    end
  end

  always @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      GLOBAL_FREEZE_OUT <= 1'b0;
      PMI_CORES_OUT <= 15'h0000;
      WAKE_CORES_OUT <= 15'h0000;
      pmi_pend_r <= 1'b0;
    end else begin
      GLOBAL_FREEZE_OUT <= freeze_nxt;
      PMI_CORES_OUT <= pmi_nxt;
      WAKE_CORES_OUT <= wake_nxt;
      pmi_pend_r <= pend_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register reads
  reg [63:0] rd_mux;
  reg rd_hit;

  always @* begin
    rd_mux = 64'h0000_0000_0000_0000;
    rd_hit = 1'b1;
    case (MSR_ADDR_IN)
      `UMON_ADDR_GCTL: begin
        rd_mux = {32'h0000_0000, 1'b0, gctl_wake_r, 1'b0, 14'h0000, gctl_cores_r};
      end
      `UMON_ADDR_GSTAT: begin
        rd_mux = {37'h0, gstat_r};
      end
      `UMON_ADDR_GCFG: begin
        rd_mux = {60'h0, gcfg_r};
      end
      `UMON_ADDR_FIX_CTL: begin
        rd_mux = {41'h0, fix_en_r, 1'b0, fix_wme_r, 20'h0_0000};
      end
      `UMON_ADDR_FIX_CTR: begin
        rd_mux = {16'h0000, fix_cnt};
      end
      `UMON_ADDR_CTL0: begin
        rd_mux = {32'h0000_0000, ctl_flat_r[31:0]};
      end
      `UMON_ADDR_CTL1: begin
        rd_mux = {32'h0000_0000, ctl_flat_r[63:32]};
      end
      `UMON_ADDR_BOX_STAT: begin
        rd_mux = {62'h0, box_stat_r};
      end
      `UMON_ADDR_CTR0: begin
        rd_mux = {16'h0000, gen_cnt[`UMON_CTR_W-1:0]};
      end
      `UMON_ADDR_CTR1: begin
        rd_mux = {16'h0000, gen_cnt[2*`UMON_CTR_W-1:`UMON_CTR_W]};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      MSR_RDATA_OUT <= 64'h0000_0000_0000_0000;
      MSR_ACK_OUT <= 1'b0;
      MSR_ERR_OUT <= 1'b0;
    end else begin
      MSR_ACK_OUT <= MSR_RD_IN | MSR_WR_IN;
      MSR_ERR_OUT <= (MSR_RD_IN | MSR_WR_IN) & ~rd_hit;
      if (MSR_RD_IN) begin
        MSR_RDATA_OUT <= rd_mux;
      end
    end
  end

endmodule

// File: src/umon_global_map.vh
`ifndef UMON_GLOBAL_MAP_VH
`define UMON_GLOBAL_MAP_VH

////////////////////////////////////////////////////////////////////////
// register addresses
`define UMON_ADDR_GCTL 12'h0c00
`define UMON_ADDR_GSTAT 12'h0c01
`define UMON_ADDR_GCFG 12'h0c06
`define UMON_ADDR_FIX_CTL 12'h0c08
`define UMON_ADDR_FIX_CTR 12'h0c09
`define UMON_ADDR_CTL0 12'h0c10
`define UMON_ADDR_CTL1 12'h0c11
`define UMON_ADDR_BOX_STAT 12'h0c15
`define UMON_ADDR_CTR0 12'h0c16
`define UMON_ADDR_CTR1 12'h0c17

////////////////////////////////////////////////////////////////////////
// global control fields
`define UMON_GCTL_HOLD_SET 31
`define UMON_GCTL_WAKE 30
`define UMON_GCTL_HOLD_REL 29
`define UMON_GCTL_CORES_MSB 14
`define UMON_CORES 15

////////////////////////////////////////////////////////////////////////
// global status and config
`define UMON_GSTAT_W 27
`define UMON_BOXES 25
`define UMON_GSTAT_FIXED 0
`define UMON_GSTAT_GEN 1
`define UMON_GCFG_W 4
`define UMON_GCFG_RESET 4'h8

////////////////////////////////////////////////////////////////////////
// counter control fields
`define UMON_CTL_EVT_LSB 0
`define UMON_CTL_SUB_LSB 8
`define UMON_CTL_EDGE 18
`define UMON_CTL_WME 20
`define UMON_CTL_EN 22
`define UMON_CTL_LVL_LSB 24
`define UMON_CTL_RESET 32'h0000_0000

////////////////////////////////////////////////////////////////////////
// counters
`define UMON_CTR_W 48
`define UMON_NCTR 2
`define UMON_EVT_W 32

`endif

// File: test/umon_box_model.sv
`timescale 1ns/10ps
// far side: counting boxes sending wrap messages, cores reporting sleep state
// occupancy clear bits belong to box software, so boxes here only pulse wraps
module umon_box_model (
  input wire clk_in,
  input wire [24:0] fire_in,
  input wire [14:0] sleep_in,
  output reg [24:0] msg_out,
  output reg [14:0] awake_out
);
  initial begin
    msg_out = 25'h000_0000;
    awake_out = 15'h7fff;
  end
  // messages are single-cycle pulses launched on the clock
  always @(posedge clk_in) begin
    msg_out <= fire_in;
    awake_out <= ~sleep_in;
  end
endmodule

// File: test/umon_ctl_properties.sv
`timescale 1ns/10ps
`include "umon_global_map.vh"
module umon_ctl_checker (
  input wire MCLK_IN,
  input wire RST_N_IN,
  input wire [11:0] MSR_ADDR_IN,
  input wire MSR_WR_IN,
  input wire MSR_RD_IN,
  input wire [63:0] MSR_WDATA_IN,
  input wire MSR_ACK_OUT,
  input wire MSR_ERR_OUT,
  input wire [24:0] BOX_WRAP_MSG_IN,
  input wire [14:0] CORE_AWAKE_IN,
  input wire GLOBAL_FREEZE_OUT,
  input wire [14:0] PMI_CORES_OUT,
  input wire [14:0] WAKE_CORES_OUT
);
  logic [14:0] cores_r;
  logic wake_r;
  wire gwr = MSR_WR_IN && MSR_ADDR_IN == `UMON_ADDR_GCTL;
  wire msg = |BOX_WRAP_MSG_IN;
  wire mapped = MSR_ADDR_IN inside {12'h0c00, 12'h0c01, 12'h0c06, 12'h0c08, 12'h0c09,
    12'h0c10, 12'h0c11, 12'h0c15, 12'h0c16, 12'h0c17};
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // shadow of target mask and wake bit
  always @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cores_r <= 15'h0000;
      wake_r <= 1'b0;
    end else if (gwr) begin
      cores_r <= MSR_WDATA_IN[14:0];
      wake_r <= MSR_WDATA_IN[30];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  property p_msg_freeze;
    msg |=> GLOBAL_FREEZE_OUT;
  endproperty
  a_msg_freeze: assert property (p_msg_freeze) else $error("no freeze after box message");
  property p_hold_freeze;
    gwr && MSR_WDATA_IN[31] |=> GLOBAL_FREEZE_OUT;
  endproperty
  a_hold_freeze: assert property (p_hold_freeze) else $error("hold set did not freeze");
  property p_freeze_holds;
    GLOBAL_FREEZE_OUT && !(gwr && MSR_WDATA_IN[29]) |=> GLOBAL_FREEZE_OUT;
  endproperty
  a_freeze_holds: assert property (p_freeze_holds) else $error("freeze dropped without release");
  property p_pmi_in_mask;
    (PMI_CORES_OUT & ~(cores_r | $past(cores_r) | $past(cores_r, 2))) == 15'h0000;
  endproperty
  a_pmi_in_mask: assert property (p_pmi_in_mask) else $error("interrupt outside target mask");
  property p_wake_only_set;
    WAKE_CORES_OUT != 15'h0000 |-> $past(wake_r) && (WAKE_CORES_OUT & ~$past(cores_r)) == 15'h0000;
  endproperty
  a_wake_only_set: assert property (p_wake_only_set) else $error("wake without wake bit");
  property p_no_wake_pmi;
    msg && !wake_r |=> PMI_CORES_OUT == $past(cores_r & CORE_AWAKE_IN);
  endproperty
  a_no_wake_pmi: assert property (p_no_wake_pmi) else $error("interrupt mask wrong");
  property p_wake_pmi;
    msg && wake_r |=> WAKE_CORES_OUT == $past(cores_r & ~CORE_AWAKE_IN) ##1 PMI_CORES_OUT == $past(cores_r, 2);
  endproperty
  a_wake_pmi: assert property (p_wake_pmi) else $error("wake then interrupt order wrong");
  property p_err;
    (MSR_RD_IN || MSR_WR_IN) && !mapped |=> MSR_ACK_OUT && MSR_ERR_OUT;
  endproperty
  a_err: assert property (p_err) else $error("unmapped access not flagged");
endmodule

// File: test/umon_tb.sv
`timescale 1ns/10ps
`include "umon_global_map.vh"
module testbench;
  localparam logic [31:0] HS = 32'h8000_0000;
  localparam logic [31:0] REL = 32'h2000_0000;
  localparam logic [31:0] EN = 32'h0040_0000;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0;
  logic [11:0] addr = 0;
  logic [63:0] wdata = 0, rdat, v0, ex;
  logic [31:0] events = 0;
  logic [24:0] fire = 0, b;
  logic [14:0] sleep = 0, cores;
  logic [7:0] sub, lvl, cnt;
  wire [63:0] rdata_w;
  wire ack, err, frz;
  wire [24:0] msg;
  wire [14:0] awake, pmi, wake;
  int n_mismatch = 0, num_checks = 0, cyc = 0, i, k;
  umon_global_ctl dut (.MCLK_IN(clk), .RST_N_IN(rst_n), .MSR_ADDR_IN(addr), .MSR_WR_IN(wr), .MSR_RD_IN(rd),
    .MSR_WDATA_IN(wdata), .MSR_RDATA_OUT(rdata_w), .MSR_ACK_OUT(ack), .MSR_ERR_OUT(err),
    .BOX_WRAP_MSG_IN(msg), .EVENTS_IN(events), .CORE_AWAKE_IN(awake), .GLOBAL_FREEZE_OUT(frz),
    .PMI_CORES_OUT(pmi), .WAKE_CORES_OUT(wake));
  umon_box_model peer (.clk_in(clk), .fire_in(fire), .sleep_in(sleep), .msg_out(msg), .awake_out(awake));
  initial forever #25 clk = ~clk;
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      $display("BAD %0t timeout", $time);
      test_done;
    end
  end
  task chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one access: strobe for one edge, answer checked in the ack cycle
  task acc(input logic w, input logic [11:0] a, input logic [63:0] d, input logic e);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 0;
    rd <= 0;
    #1;
    rdat = rdata_w;
    chk({ack, err}, {1'b1, e});
  endtask
  task wr_reg(input logic [11:0] a, input logic [63:0] d);
    acc(1, a, d, 0);
  endtask
  task rd_reg(input logic [11:0] a);
    acc(0, a, 0, 0);
  endtask
  task box_msg(input logic [24:0] m, input logic wk);
    @(posedge clk);
    fire <= m;
    @(posedge clk);
    fire <= 0;
    @(posedge clk);
    #1;
    chk(frz, 1);
    chk(wk ? wake : pmi, wk ? cores & sleep : cores & ~sleep);
    @(posedge clk);
    #1;
    if (wk) chk(pmi, cores);
  endtask
  initial begin
    void'($urandom(32'h2e4a_d5d5));
    repeat (3) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    rd_reg(`UMON_ADDR_GCTL);
    chk(rdat, 0);
    rd_reg(`UMON_ADDR_GCFG);
    chk(rdat, 8);
    rd_reg(`UMON_ADDR_CTR0);
    chk(rdat, 0);
    acc(0, 12'h0c02, 0, 1);
    acc(1, 12'h0c20, 64'hffff, 1);
    wr_reg(`UMON_ADDR_GCTL, HS);
    chk(frz, 1);
    wr_reg(`UMON_ADDR_GCTL, REL);
    chk(frz, 0);
    wr_reg(`UMON_ADDR_FIX_CTL, EN);
    rd_reg(`UMON_ADDR_FIX_CTR);
    v0 = rdat;
    repeat (10) @(posedge clk);
    rd_reg(`UMON_ADDR_FIX_CTR);
    chk(rdat - v0, 12);
    wr_reg(`UMON_ADDR_GCTL, HS | REL);
    rd_reg(`UMON_ADDR_FIX_CTR);
    v0 = rdat;
    repeat (10) @(posedge clk);
    rd_reg(`UMON_ADDR_FIX_CTR);
    chk(rdat, v0);
    wr_reg(`UMON_ADDR_FIX_CTR, 0);
    rd_reg(`UMON_ADDR_FIX_CTR);
    chk(rdat, 0);
    for (i = 0; i < 2; i++) begin
      wr_reg(`UMON_ADDR_GCTL, HS);
      wr_reg(`UMON_ADDR_FIX_CTL, EN | (i << 20));
      wr_reg(`UMON_ADDR_FIX_CTR, 48'hffff_ffff_ffec);
      wr_reg(`UMON_ADDR_GCTL, REL);
      repeat (10) @(posedge clk);
      #1 chk(frz, 0);
      repeat (30) @(posedge clk);
      #1 chk(frz, i);
      rd_reg(`UMON_ADDR_GSTAT);
      chk(rdat, i);
      wr_reg(`UMON_ADDR_GSTAT, 1);
      rd_reg(`UMON_ADDR_GSTAT);
      chk(rdat, 0);
    end
    wr_reg(`UMON_ADDR_FIX_CTL, 0);
    wr_reg(`UMON_ADDR_GCTL, REL);
    @(posedge clk);
    events <= $urandom;
    for (i = 0; i < 10; i++) begin
      sub = $urandom;
      lvl = $urandom % 4;
      wr_reg(`UMON_ADDR_CTL0 + i[0], EN | (lvl << 24) | (sub << 8) | (i % 5));
      rd_reg(`UMON_ADDR_CTR0 + i[0]);
      v0 = rdat;
      repeat (10) @(posedge clk);
      rd_reg(`UMON_ADDR_CTR0 + i[0]);
      cnt = (i % 5 == 0) ? 0 : $countones(events[8 * (i % 5 - 1) +: 8] & sub);
      ex = 12 * ((lvl == 0) ? cnt : (cnt >= lvl));
      chk(rdat - v0, ex);
    end
    // rising-edge filter: five pulses give five counts
    @(posedge clk);
    events <= 0;
    wr_reg(`UMON_ADDR_CTL1, EN | 32'h0004_ff01);
    rd_reg(`UMON_ADDR_CTR1);
    v0 = rdat;
    repeat (5) begin
      @(posedge clk);
      events <= 1;
      @(posedge clk);
      events <= 0;
    end
    rd_reg(`UMON_ADDR_CTR1);
    chk(rdat - v0, 5);
    // general counter wrap with message enabled, then per-counter flag
    wr_reg(`UMON_ADDR_GCTL, HS);
    wr_reg(`UMON_ADDR_CTR0, 48'hffff_ffff_fffb);
    wr_reg(`UMON_ADDR_CTL0, EN | 32'h0010_0101);
    @(posedge clk);
    events <= 1;
    wr_reg(`UMON_ADDR_GCTL, REL);
    repeat (10) @(posedge clk);
    #1 chk(frz, 1);
    rd_reg(`UMON_ADDR_CTR0);
    chk(rdat, 0);
    rd_reg(`UMON_ADDR_BOX_STAT);
    chk(rdat, 1);
    rd_reg(`UMON_ADDR_GSTAT);
    chk(rdat, 2);
    wr_reg(`UMON_ADDR_BOX_STAT, 1);
    rd_reg(`UMON_ADDR_BOX_STAT);
    chk(rdat, 0);
    wr_reg(`UMON_ADDR_GSTAT, 2);
    rd_reg(`UMON_ADDR_GSTAT);
    chk(rdat, 0);
    wr_reg(`UMON_ADDR_CTL0, 0);
    wr_reg(`UMON_ADDR_CTL1, 0);
    wr_reg(`UMON_ADDR_GCTL, REL);
    for (i = 0; i < 6; i++) begin
      k = $urandom % 25;
      cores = 15'($urandom);
      @(posedge clk);
      sleep <= 15'($urandom);
      wr_reg(`UMON_ADDR_GCTL, (i[0] << 30) | cores);
      b = 25'h1 << k;
      if (i == 5) b = b | (25'h1 << ((k + 9) % 25));
      box_msg(b, i[0]);
      rd_reg(`UMON_ADDR_GSTAT);
      chk(rdat, {b, 2'b00});
      wr_reg(`UMON_ADDR_GSTAT, {b, 2'b00});
      rd_reg(`UMON_ADDR_GSTAT);
      chk(rdat, 0);
      wr_reg(`UMON_ADDR_GCTL, REL);
      chk(frz, 0);
    end
    test_done;
  end
endmodule
bind umon_global_ctl umon_ctl_checker u_chk (.MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN), .MSR_ADDR_IN(MSR_ADDR_IN),
  .MSR_WR_IN(MSR_WR_IN), .MSR_RD_IN(MSR_RD_IN), .MSR_WDATA_IN(MSR_WDATA_IN), .MSR_ACK_OUT(MSR_ACK_OUT),
  .MSR_ERR_OUT(MSR_ERR_OUT), .BOX_WRAP_MSG_IN(BOX_WRAP_MSG_IN), .CORE_AWAKE_IN(CORE_AWAKE_IN),
  .GLOBAL_FREEZE_OUT(GLOBAL_FREEZE_OUT), .PMI_CORES_OUT(PMI_CORES_OUT), .WAKE_CORES_OUT(WAKE_CORES_OUT));
